// *** hdl/mrf_defines.svh ***
// Constants for the MAC receive mode and filter control block
`ifndef MRF_DEFINES_SVH
`define MRF_DEFINES_SVH
`define MRF_ADDR_MODE_CONTROL 8'h80
`define MRF_ADDR_STATION_HI 8'h84
`define MRF_ADDR_STATION_LO 8'h88
`define MRF_ADDR_STATUS 8'hC0
`define MRF_BIT_RECEIVE_EVERY 31
`define MRF_BIT_BLOCK_SELF 23
`define MRF_BIT_LOOPBACK 21
`define MRF_BIT_FULL_DUPLEX 20
`define MRF_BIT_GROUP_ALL 19
`define MRF_BIT_ANY_DEST 18
`define MRF_BIT_INVERSE 17
`define MRF_BIT_DAMAGED 16
`define MRF_BIT_HASH_SELECT 13
`define MRF_CTRL_WMASK 32'h80BF2000
`define MRF_CTRL_RESET 32'h00040000
`define MRF_LOOP_SETTLE_NS 10000
`define MRF_CLK_PERIOD_NS 10
`endif

// *** hdl/mrf_pkg.sv ***
// Types for the MAC receive mode and filter control block
package mrf_pkg;
   typedef enum logic [1:0] {RX_IDLE, RX_DEST, RX_BODY} mrf_rx_state_e;
endpackage : mrf_pkg

// *** hdl/mrf_mac_rx_mode_filter_control.sv ***
// MAC mode control register, loopback mux and receive address filter
`timescale 1ns/1ps
`include "mrf_defines.svh"
module mrf_mac_rx_mode_filter_control
   import mrf_pkg::*;
#(
   parameter int unsigned LOOP_SETTLE_CYC = `MRF_LOOP_SETTLE_NS / `MRF_CLK_PERIOD_NS
)(
   input wire logic clock_i, // 100 MHz
   input wire logic rstn_i, // Async reset, active low
   input wire logic [7:0] reg_addr_i, // Register byte address
   input wire logic [31:0] reg_wdata_i, // Write data
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   output logic [31:0] reg_rdata_o, // Read data, one cycle later
   input wire logic mac_txen_i, // MAC transmit enable
   input wire logic [3:0] mac_txd_i, // MAC transmit nibble
   output logic phy_txen_o, // To PHY transmit enable
   output logic [3:0] phy_txd_o, // To PHY transmit nibble
   input wire logic phy_rxdv_i, // PHY receive valid (pin)
   input wire logic [3:0] phy_rxd_i, // PHY receive nibble (pin)
   input wire logic rx_err_i, // Frame damaged: runt, collision, underrun
   output logic rx_dv_o, // Receive valid toward MAC core
   output logic [3:0] rx_d_o, // Receive nibble toward MAC core
   output logic frame_done_o, // Pulse at frame end
   output logic frame_pass_o, // Frame goes to the application
   output logic frame_addr_ok_o, // Filter outcome for receive status
   output logic full_duplex_o, // Full duplex mode
   output logic loop_settled_o // Loopback mode change has settled
);
   // Control register and station address
   logic [31:0] ctrl_reg, ctrl_next;
   logic [47:0] station_reg, station_next;
   logic [31:0] rdata_reg, rdata_next;
   // Two-flop synchroniser on PHY pins
   logic [4:0] rx_s1_reg, rx_s2_reg;
   // Loopback path, settle counter
   logic loop_reg, loop_next;
   logic [15:0] settle_reg, settle_next;
   // Receive filter state
   mrf_rx_state_e state_reg, state_next;
   logic [47:0] dest_reg, dest_next;
   logic [3:0] nib_reg, nib_next;
   // Filter settings are frozen per frame so a mid-frame write cannot split a decision
   logic [7:0] cfg_reg, cfg_next;
   logic bad_reg, bad_next;
   logic done_reg, done_next;
   logic pass_reg, pass_next;
   logic ok_reg, ok_next;
   logic dv_reg, dv_next;
   logic [3:0] d_reg, d_next;
   logic blocked_reg, blocked_next;
   logic in_dv;
   logic [3:0] in_d;
   logic match;
   logic addr_ok;

   // Register write and read decode
   always_comb
   begin
      ctrl_next = ctrl_reg;
      station_next = station_reg;
      rdata_next = 32'h00000000;
      // Reserved control bits are dropped by the write mask and read back as zero
      if (reg_wr_i)
      begin
         unique case (reg_addr_i)
            `MRF_ADDR_MODE_CONTROL: ctrl_next = reg_wdata_i & `MRF_CTRL_WMASK;
            `MRF_ADDR_STATION_HI: station_next[47:32] = reg_wdata_i[15:0];
            `MRF_ADDR_STATION_LO: station_next[31:0] = reg_wdata_i;
            default: ;
         endcase
      end
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            `MRF_ADDR_MODE_CONTROL: rdata_next = ctrl_reg;
            `MRF_ADDR_STATION_HI: rdata_next = {16'h0000, station_reg[47:32]};
            `MRF_ADDR_STATION_LO: rdata_next = station_reg[31:0];
            `MRF_ADDR_STATUS: rdata_next = {28'h0000000, loop_settled_o, loop_reg, ok_reg, pass_reg};
            default: rdata_next = 32'h00000000;
         endcase
      end
   end

   // Pin inputs are asynchronous to the MAC clock
   // Only the second stage feeds logic; the first may still be settling
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rx_s1_reg <= 5'h00;
         rx_s2_reg <= 5'h00;
      end
      else
      begin
         rx_s1_reg <= {phy_rxdv_i, phy_rxd_i};
         rx_s2_reg <= rx_s1_reg;
      end
   end

   // Loopback path switches after the settle time whatever the frame state, so a change mid-frame can still tear a frame
   // The count restarts once path and bit agree, so undoing a change costs nothing
   always_comb
   begin
      loop_next = loop_reg;
      settle_next = settle_reg;
      if (ctrl_reg[`MRF_BIT_LOOPBACK] != loop_reg)
      begin
         if (settle_reg >= 16'(LOOP_SETTLE_CYC - 1))
         begin
            loop_next = ctrl_reg[`MRF_BIT_LOOPBACK];
            settle_next = 16'h0000;
         end
         else
         begin
            settle_next = settle_reg + 16'h0001;
         end
      end
      else
      begin
         settle_next = 16'h0000;
      end
   end

   // Internal loopback feeds transmit back and keeps the PHY quiet
   // The synchroniser keeps running in loopback, so leaving it needs no refill time
   always_comb
   begin
      if (loop_reg)
      begin
         phy_txen_o = 1'b0;
         phy_txd_o = 4'h0;
         in_dv = mac_txen_i;
         in_d = mac_txd_i;
      end
      else
      begin
         phy_txen_o = mac_txen_i;
         phy_txd_o = mac_txd_i;
         in_dv = rx_s2_reg[4];
         in_d = rx_s2_reg[3:0];
      end
   end

   // Perfect match against station address, with modes
   // With hash select set, inverse has no meaning, since it only applies to perfect filtering
   always_comb
   begin
      match = (dest_reg == station_reg);
      if (!cfg_reg[1])
      begin
         addr_ok = cfg_reg[3] ? !match : match;
      end
      else
      begin
         addr_ok = match; // Hash table lives elsewhere; only the exact entry is checked here
      end
      if (cfg_reg[4] && dest_reg[0])
      begin
         addr_ok = 1'b1;
      end
      // Unicast under group-pass still falls to the match above
      if (cfg_reg[5])
      begin
         addr_ok = 1'b1;
      end
   end

   // Frame sequencing: snapshot config at start, collect destination, judge at end
   always_comb
   begin
      state_next = state_reg;
      dest_next = dest_reg;
      nib_next = nib_reg;
      cfg_next = cfg_reg;
      bad_next = bad_reg;
      done_next = 1'b0;
      pass_next = pass_reg;
      ok_next = ok_reg;
      blocked_next = blocked_reg;
      dv_next = 1'b0;
      d_next = 4'h0;
      // Pulses and the stream drop unless set below
      unique case (state_reg)
         RX_IDLE:
         begin
            if (in_dv)
            begin
               // Receive runs while transmitting unless block-self is set outside loopback; the full duplex bit plays no part
               // Own-transmit blocking is judged once, when the frame starts
               blocked_next = ctrl_reg[`MRF_BIT_BLOCK_SELF] && mac_txen_i && !loop_reg;
               // Snapshot of the filter settings for this frame
               cfg_next[7] = ctrl_reg[`MRF_BIT_RECEIVE_EVERY];
               cfg_next[6] = ctrl_reg[`MRF_BIT_DAMAGED];
               cfg_next[5] = ctrl_reg[`MRF_BIT_ANY_DEST];
               cfg_next[4] = ctrl_reg[`MRF_BIT_GROUP_ALL];
               cfg_next[3] = ctrl_reg[`MRF_BIT_INVERSE];
               cfg_next[2] = ctrl_reg[`MRF_BIT_FULL_DUPLEX];
               cfg_next[1] = ctrl_reg[`MRF_BIT_HASH_SELECT];
               cfg_next[0] = 1'b0; // Spare
               dest_next = {in_d, 44'h00000000000};
               nib_next = 4'h1;
               bad_next = rx_err_i;
               state_next = RX_DEST;
            end
         end
         RX_DEST, RX_BODY:
         begin
            if (in_dv)
            begin
               bad_next = bad_reg | rx_err_i;
               if (state_reg == RX_DEST)
               begin
                  // Nibbles enter at the top, so the first one ends lowest
                  dest_next = {in_d, dest_reg[47:4]};
                  nib_next = nib_reg + 4'h1;
                  if (nib_reg == 4'hB)
                  begin
                     state_next = RX_BODY;
                  end
               end
            end
            else
            begin
               // A blocked frame was never delivered, so its end leaves the decision alone
               if (!blocked_reg)
               begin
                  done_next = 1'b1;
                  // Frames shorter than the destination field fail the length test
                  ok_next = addr_ok && (nib_reg == 4'hC);
                  // Receive-all forwards every frame; otherwise address and soundness decide
                  pass_next = cfg_reg[7] ||
                     (addr_ok && (nib_reg == 4'hC) && (!bad_next || cfg_reg[6]));
               end
               blocked_next = 1'b0;
               state_next = RX_IDLE;
            end
         end
      endcase
      if (in_dv && state_next != RX_IDLE && !blocked_next)
      begin
         dv_next = 1'b1;
         d_next = in_d;
      end
   end

   // Registers
   // Every register resets to a constant; the control word starts promiscuous
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ctrl_reg <= `MRF_CTRL_RESET;
         station_reg <= 48'h000000000000;
         rdata_reg <= 32'h00000000;
         loop_reg <= 1'b0;
         settle_reg <= 16'h0000;
         state_reg <= RX_IDLE;
         dest_reg <= 48'h000000000000;
         nib_reg <= 4'h0;
         cfg_reg <= 8'h00;
         bad_reg <= 1'b0;
         done_reg <= 1'b0;
         pass_reg <= 1'b0;
         ok_reg <= 1'b0;
         dv_reg <= 1'b0;
         d_reg <= 4'h0;
         blocked_reg <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         station_reg <= station_next;
         rdata_reg <= rdata_next;
         loop_reg <= loop_next;
         settle_reg <= settle_next;
         state_reg <= state_next;
         dest_reg <= dest_next;
         nib_reg <= nib_next;
         cfg_reg <= cfg_next;
         bad_reg <= bad_next;
         done_reg <= done_next;
         pass_reg <= pass_next;
         ok_reg <= ok_next;
         dv_reg <= dv_next;
         d_reg <= d_next;
         blocked_reg <= blocked_next;
      end
   end

   // Outputs
   // Decisions come straight from flip-flops, so the core never sees a glitch
   assign reg_rdata_o = rdata_reg;
   assign rx_dv_o = dv_reg;
   assign rx_d_o = d_reg;
   assign frame_done_o = done_reg;
   assign frame_pass_o = pass_reg;
   assign frame_addr_ok_o = ok_reg;
   assign full_duplex_o = ctrl_reg[`MRF_BIT_FULL_DUPLEX];
   assign loop_settled_o = (ctrl_reg[`MRF_BIT_LOOPBACK] == loop_reg);
endmodule : mrf_mac_rx_mode_filter_control

// *** verif/mrf_checker.sv ***
// Checker for the mode, loopback and receive filter ports
`timescale 1ns/1ps
`include "mrf_defines.svh"
module mrf_checker #(
   parameter int unsigned LOOP_SETTLE_CYC = `MRF_LOOP_SETTLE_NS / `MRF_CLK_PERIOD_NS
)(
   input wire logic clock_i, // Clock
   input wire logic rstn_i, // Reset, active low
   input wire logic [7:0] reg_addr_i, // Address
   input wire logic [31:0] reg_wdata_i, // Write data
   input wire logic reg_wr_i, // Write strobe
   input wire logic mac_txen_i, // MAC transmit enable
   input wire logic phy_txen_o, // PHY transmit enable
   input wire logic [3:0] phy_txd_o, // PHY transmit nibble
   input wire logic phy_rxdv_i, // PHY receive valid
   input wire logic [3:0] phy_rxd_i, // PHY receive nibble
   input wire logic rx_dv_o, // Receive valid to core
   input wire logic [3:0] rx_d_o, // Receive nibble to core
   input wire logic frame_done_o, // Frame end pulse
   input wire logic frame_pass_o, // Forward decision
   input wire logic full_duplex_o, // Full duplex flag
   input wire logic loop_settled_o // Loopback settled
);
   // A single loopback change settles in exactly this many cycles
   localparam int LIM = int'(LOOP_SETTLE_CYC);
   logic ctl_wr;
   logic lb_reg;
   logic lb_next;
   logic blk_reg;
   logic blk_next;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   // Shadow of bits 21 and 23 as last written, so checks know the mode
   assign ctl_wr = reg_wr_i && reg_addr_i == 8'h80;
   always_comb
   begin
      lb_next = ctl_wr ? reg_wdata_i[21] : lb_reg;
      blk_next = ctl_wr ? reg_wdata_i[23] : blk_reg;
   end
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         {lb_reg, blk_reg} <= 2'b00;
      else
         {lb_reg, blk_reg} <= {lb_next, blk_next};
   end
   property p_fd;
      ctl_wr ##1 !ctl_wr |=> full_duplex_o == $past(reg_wdata_i[20], 2);
   endproperty
   a_fd: assert property (p_fd) else $error("duplex flag wrong");
   property p_quiet;
      lb_reg && loop_settled_o |-> !phy_txen_o && phy_txd_o == 4'h0;
   endproperty
   a_quiet: assert property (p_quiet) else $error("PHY driven in loopback");
   property p_copy;
      !lb_reg && loop_settled_o |-> phy_txen_o == mac_txen_i;
   endproperty
   a_copy: assert property (p_copy) else $error("PHY transmit not passed");
   property p_settle;
      $fell(loop_settled_o) |-> ##[1:LIM] loop_settled_o;
   endproperty
   a_settle: assert property (p_settle) else $error("loopback slow to settle");
   property p_rx;
      (!lb_reg && !blk_reg && loop_settled_o) [*4] |-> rx_dv_o == $past(phy_rxdv_i, 3);
   endproperty
   a_rx: assert property (p_rx) else $error("receive path lost");
   property p_rxd;
      (!lb_reg && !blk_reg && loop_settled_o) [*4] |->
         rx_d_o == ($past(phy_rxdv_i, 3) ? $past(phy_rxd_i, 3) : 4'h0);
   endproperty
   a_rxd: assert property (p_rxd) else $error("receive nibble lost");
   property p_lrx;
      (lb_reg && loop_settled_o) [*2] |-> rx_dv_o == $past(mac_txen_i);
   endproperty
   a_lrx: assert property (p_lrx) else $error("loopback receive wrong");
   property p_blk;
      blk_reg && !lb_reg && mac_txen_i && $past(phy_rxdv_i, 2) && !$past(phy_rxdv_i, 3) |=> !rx_dv_o;
   endproperty
   a_blk: assert property (p_blk) else $error("own frame received");
   property p_edge;
      $changed(frame_pass_o) |-> frame_done_o;
   endproperty
   a_edge: assert property (p_edge) else $error("decision moved mid frame");
endmodule : mrf_checker
bind mrf_mac_rx_mode_filter_control mrf_checker #(.LOOP_SETTLE_CYC(LOOP_SETTLE_CYC)) u_chk (.clock_i, .rstn_i,
   .reg_addr_i, .reg_wdata_i, .reg_wr_i, .mac_txen_i, .phy_txen_o, .phy_txd_o, .phy_rxdv_i, .phy_rxd_i,
   .rx_dv_o, .rx_d_o, .frame_done_o, .frame_pass_o, .full_duplex_o, .loop_settled_o);

// *** verif/mrf_phy_model.sv ***
// PHY receive side model sending nibble frames
`timescale 1ns/1ps
module mrf_phy_model (
   input wire logic clock_i, // Clock
   output logic phy_rxdv_o, // Receive valid
   output logic [3:0] phy_rxd_o // Receive nibble
);
   initial
   begin
      phy_rxdv_o = 1'b0;
      phy_rxd_o = 4'hA;
   end
   // Low nibble first; idle data inverted so stale data never looks valid
   task automatic send(input logic [47:0] d, input int gap);
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clock_i);
         phy_rxdv_o <= 1'b1;
         phy_rxd_o <= (i < 12) ? d[4*i +: 4] : 4'h5;
      end
      @(posedge clock_i);
      phy_rxdv_o <= 1'b0;
      phy_rxd_o <= ~phy_rxd_o;
      repeat (gap) @(posedge clock_i);
   endtask : send
endmodule : mrf_phy_model

// *** verif/mrf_mac_rx_mode_filter_control_tb.sv ***
// Testbench for the MAC mode control and receive filter block
`timescale 1ns/1ps
module mrf_mac_rx_mode_filter_control_tb;
   localparam int LOOP = 4;
   localparam logic [47:0] STA = 48'h665544332210;
   localparam logic [47:0] OTH = 48'h0A0B0C0D0E02;
   localparam logic [47:0] GRP = 48'h0A0B0C0D0E03;
   // Control, destination, then damaged, pass and filter outcome
   localparam logic [82:0] TBL [14] = '{{32'h00040000, OTH, 3'b011}, {32'h0, STA, 3'b011},
      {32'h0, OTH, 3'b000}, {32'h0, GRP, 3'b000}, {32'h00080000, GRP, 3'b011}, {32'h00080000, OTH, 3'b000},
      {32'h00080000, STA, 3'b011}, {32'h00020000, STA, 3'b000}, {32'h00020000, OTH, 3'b011},
      {32'h00022000, OTH, 3'b000}, {32'h80000000, OTH, 3'b010}, {32'h0, STA, 3'b101},
      {32'h00010000, STA, 3'b111}, {32'h00010000, OTH, 3'b100}};
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h0;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic mac_txen_i = 1'b0;
   logic [3:0] mac_txd_i = 4'h0;
   logic rx_err_i = 1'b0;
   logic [31:0] reg_rdata_o;
   logic phy_txen_o, phy_rxdv_i, rx_dv_o, frame_done_o, frame_pass_o, frame_addr_ok_o, full_duplex_o;
   logic loop_settled_o;
   logic [3:0] phy_txd_o, phy_rxd_i, rx_d_o;
   int n_mismatch = 0;
   int num_checks = 0;
   always #5 clock_i = ~clock_i;
   mrf_mac_rx_mode_filter_control #(.LOOP_SETTLE_CYC(LOOP)) DUT (.clock_i, .rstn_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .mac_txen_i, .mac_txd_i, .phy_txen_o, .phy_txd_o, .phy_rxdv_i,
      .phy_rxd_i, .rx_err_i, .rx_dv_o, .rx_d_o, .frame_done_o, .frame_pass_o, .frame_addr_ok_o,
      .full_duplex_o, .loop_settled_o);
   mrf_phy_model u_phy (.clock_i, .phy_rxdv_o(phy_rxdv_i), .phy_rxd_o(phy_rxd_i));
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, exp);
   endtask : rd
   // MAC transmit frame, same nibble order as received frames
   task automatic tx(input logic [47:0] d);
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clock_i);
         mac_txen_i <= 1'b1;
         mac_txd_i <= (i < 12) ? d[4*i +: 4] : 4'h5;
      end
      @(posedge clock_i);
      mac_txen_i <= 1'b0;
   endtask : tx
   // Bounded wait for the end pulse, then the decision and filter outcome
   task automatic fin(input logic want, input logic [1:0] exp);
      logic got;
      got = 1'b0;
      for (int i = 0; i < 12 && got !== 1'b1; i++)
         @(posedge clock_i) #1 got = frame_done_o;
      chk(got, want);
      if (want && got !== 1'b1)
         conclude();
      if (got === 1'b1)
         chk({frame_pass_o, frame_addr_ok_o}, exp);
   endtask : fin
   // Mode change must not land at once, and software then waits before traffic
   task automatic settle();
      #1 chk(loop_settled_o, 1'b0);
      for (int i = 0; i < LOOP + 8 && loop_settled_o !== 1'b1; i++)
         @(posedge clock_i) #1;
      chk(loop_settled_o, 1'b1);
      if (loop_settled_o !== 1'b1)
         conclude();
      repeat (LOOP) @(posedge clock_i);
   endtask : settle
   initial
   begin
      repeat (20) @(posedge clock_i);
      rstn_i <= 1'b1;
      rd(8'h80, 32'h00040000);
      rd(8'h8C, 32'h0);
      // Every loopback flip is left to settle before the next one
      wr(8'h80, 32'hFFFFFFFF);
      settle();
      rd(8'h80, 32'h80BF2000);
      wr(8'h80, 32'h0);
      settle();
      wr(8'h84, {16'h0, STA[47:32]});
      wr(8'h88, STA[31:0]);
      for (int k = 0; k < 14; k++)
      begin
         wr(8'h80, TBL[k][82:51]);
         rx_err_i <= TBL[k][2];
         u_phy.send(TBL[k][50:3], 0);
         fin(1'b1, TBL[k][1:0]);
         rx_err_i <= 1'b0;
      end
      wr(8'h80, 32'h0);
      fork
         u_phy.send(OTH, 0);
         begin
            repeat (6) @(posedge clock_i);
            wr(8'h80, 32'h00040000);
         end
      join
      fin(1'b1, 2'b00);
      wr(8'h80, 32'h00100000);
      #1 chk(full_duplex_o, 1'b1);
      fork
         u_phy.send(STA, 0);
         tx(OTH);
      join
      fin(1'b1, 2'b11);
      wr(8'h80, 32'h00300000);
      settle();
      tx(STA);
      fin(1'b1, 2'b11);
      rd(8'hC0, 32'h0000000F);
      wr(8'h80, 32'h00100000);
      settle();
      for (int b = 0; b < 2; b++)
      begin
         wr(8'h80, (b == 1) ? 32'h00840000 : 32'h00040000);
         fork
            u_phy.send(OTH, 2);
            tx(OTH);
         join
         fin(b == 0, 2'b11);
      end
      conclude();
   end
endmodule : mrf_mac_rx_mode_filter_control_tb
